// >>> core/lcd_host_if.sv
`timescale 1ns/1ps
interface lcd_host_if;
	logic        [16:0] host_addr_in;
	logic               mem_select;
	logic        [15:0] host_data_out;
	logic        [15:0] host_data_in;
	logic               host_data_oe;
	logic        [15:0] dev_data_out;
	logic               dev_data_oe;
	logic               chip_select_n;
	logic               read_strobe_n;
	logic               low_write_strobe_n;
	logic               high_byte_enable_n;
	logic               bus_start_n;
	logic               rd_wr_dir;
	logic               wait_out;

	modport host (
		output host_addr_in, mem_select, host_data_out, host_data_oe, chip_select_n,
		output read_strobe_n, low_write_strobe_n, high_byte_enable_n, bus_start_n, rd_wr_dir,
		input  dev_data_out, dev_data_oe, wait_out, host_data_in
	);
	modport device (
		input  host_addr_in, mem_select, host_data_out, host_data_oe, chip_select_n,
		input  read_strobe_n, low_write_strobe_n, high_byte_enable_n, bus_start_n, rd_wr_dir,
		output dev_data_out, dev_data_oe, wait_out
	);
endinterface : lcd_host_if

// >>> core/lcd_port_device.sv
`timescale 1ns/1ps
// What this block does
// - host holds chip select low whole access
// - host asserts read strobe while reading
// - host asserts low write strobe writing
// - wait stretches cycle until data ready
// - wait held through refresh arbitration
// - high byte enable low for 16-bit
// - byte lanes from enable and address bit0
// - shared high enable, separate low strobes
// - select input picks registers or buffer
// - 17-bit address, 16-bit data bus
// - straps latched at reset release
// - strap value 100 selects this mode
// - endian strap swaps byte order
// - wait polarity strap sets active level
// - gpio strap sets pins input or output
// - divide straps set bus clock ratio
// - internal clocks come from host clock
// - bus start and direction ignored, tied high
module lcd_port_device
	import lcd_port_pkg::*;
(
	// clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// host bus
	lcd_host_if.device              bus,
	// configuration straps
	input  wire logic [STRAP_W-1:0] strap_pins,
	// status
	output logic                    mode_ok,
	output logic                    gpio_as_input,
	output logic      [1:0]         clock_divide,
	output logic                    bus_clock_tick
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum {ST_IDLE, ST_ARB, ST_DONE} dev_state_t;

	typedef struct packed {
		logic [1:0]        sy_cs, sy_rd, sy_wr, sy_hb;
		dev_state_t        state;
		logic [3:0]        refresh_cnt;
		logic [1:0]        busy_cnt;
		logic [1:0]        acc_cnt;
		logic [1:0]        div_cnt;
		logic              tick;
		logic              is_write;
		logic [15:0]       rdata;
		logic              drive;
		logic              wait_act;
		logic              wait_pin;
		logic              mode_ok;
		logic              gpio_in;
		logic [1:0]        divide;
	} dev_st_t;

	dev_st_t st_q;
	dev_st_t st_d;

	logic [15:0] reg_mem [REG_DEPTH];
	logic [15:0] buf_mem [MEM_DEPTH];
	logic [STRAP_W-1:0] strap;
	logic        strap_ready;
	logic [1:0]  lane;
	logic        mem_hit;
	logic [15:0] word_in;
	logic [15:0] word_rd;
	logic        do_write;
	logic [MEM_AW-1:0] buf_idx;
	logic [REG_AW-1:0] reg_idx;

	function automatic logic [15:0] swap16(input logic [15:0] w, input logic en);
		return en ? {w[7:0], w[15:8]} : w;
	endfunction : swap16

	strap_capture u_strap (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.strap_pins (strap_pins),
		.strap_q    (strap),
		.ready_q    (strap_ready)
	);

	// ****************************************************************
	// decode
	// ****************************************************************
	always_comb begin
		lane = lanes(st_q.sy_hb[1], bus.host_addr_in[0]);
		mem_hit = bus.mem_select;
		buf_idx = bus.host_addr_in[MEM_AW:1];
		reg_idx = bus.host_addr_in[REG_AW:1];
		word_in = swap16(bus.host_data_out, strap[STRAP_ENDIAN]);
		word_rd = mem_hit ? buf_mem[buf_idx] : reg_mem[reg_idx];
	end

	// ****************************************************************
	// control
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		do_write = 1'b0;
		st_d.sy_cs = {st_q.sy_cs[0], bus.chip_select_n};
		st_d.sy_rd = {st_q.sy_rd[0], bus.read_strobe_n};
		st_d.sy_wr = {st_q.sy_wr[0], bus.low_write_strobe_n};
		st_d.sy_hb = {st_q.sy_hb[0], bus.high_byte_enable_n};
		// bus clock divider from host clock
		st_d.tick = 1'b0;
		if (st_q.div_cnt == st_q.divide) begin
			st_d.div_cnt = 2'h0;
			st_d.tick = 1'b1;
		end else begin
			st_d.div_cnt = st_q.div_cnt + 2'h1;
		end
		// display refresh model occupying the memory
		st_d.refresh_cnt = st_q.refresh_cnt + 4'h1;
		if (st_q.refresh_cnt == REFRESH_PERIOD) begin
			st_d.busy_cnt = REFRESH_BUSY;
		end else if (st_q.busy_cnt != 2'h0) begin
			st_d.busy_cnt = st_q.busy_cnt - 2'h1;
		end
		// ************************************************************
		// access arbitration
		// ************************************************************
		// strobes only; bus start and direction are not looked at
		unique case (st_q.state)
			ST_IDLE: begin
				if (st_q.mode_ok && !st_q.sy_cs[1] && (!st_q.sy_rd[1] || !st_q.sy_wr[1])) begin
					st_d.state = ST_ARB;
					st_d.is_write = !st_q.sy_wr[1];
					st_d.acc_cnt = ACCESS_CYCLES;
					st_d.wait_act = 1'b1;
				end
			end
			ST_ARB: begin
				if (st_q.busy_cnt != 2'h0) begin
					st_d.wait_act = 1'b1;
				end else if (st_q.acc_cnt != 2'h0) begin
					st_d.acc_cnt = st_q.acc_cnt - 2'h1;
				end else begin
					if (st_q.is_write) begin
						do_write = 1'b1;
					end else begin
						st_d.rdata = swap16(word_rd, strap[STRAP_ENDIAN]);
						st_d.drive = 1'b1;
					end
					st_d.wait_act = 1'b0;
					st_d.state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (st_q.sy_cs[1] || (st_q.sy_rd[1] && st_q.sy_wr[1])) begin
					st_d.drive = 1'b0;
					st_d.state = ST_IDLE;
				end
			end
		endcase
		// ************************************************************
		// configuration
		// ************************************************************
		st_d.wait_pin = strap[STRAP_WAITPOL] ? st_d.wait_act : ~st_d.wait_act;
		if (strap_ready) begin
			st_d.mode_ok = strap[STRAP_BUS_LO +: 3] == BUS_GENERIC2;
			st_d.gpio_in = strap[STRAP_GPIO];
			st_d.divide = strap[STRAP_DIV_LO +: 2];
		end
	end

	// ****************************************************************
	// storage
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (do_write) begin
			if (mem_hit) begin
				if (lane[0]) buf_mem[buf_idx][7:0] <= word_in[7:0];
				if (lane[1]) buf_mem[buf_idx][15:8] <= word_in[15:8];
			end else begin
				if (lane[0]) reg_mem[reg_idx][7:0] <= word_in[7:0];
				if (lane[1]) reg_mem[reg_idx][15:8] <= word_in[15:8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '{sy_cs: 2'h3, sy_rd: 2'h3, sy_wr: 2'h3, sy_hb: 2'h3, state: ST_IDLE,
				refresh_cnt: 4'h0, busy_cnt: 2'h0, acc_cnt: 2'h0, div_cnt: 2'h0,
				tick: 1'b0, is_write: 1'b0, rdata: 16'h0000, drive: 1'b0,
				wait_act: 1'b0, wait_pin: 1'b1, mode_ok: 1'b0, gpio_in: 1'b1,
				divide: 2'h0};
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign bus.dev_data_out = st_q.rdata;
	assign bus.dev_data_oe  = st_q.drive;
	assign bus.wait_out     = st_q.wait_pin;
	assign mode_ok          = st_q.mode_ok;
	assign gpio_as_input    = st_q.gpio_in;
	assign clock_divide     = st_q.divide;
	assign bus_clock_tick   = st_q.tick;
endmodule : lcd_port_device

// >>> core/lcd_port_host.sv
`timescale 1ns/1ps
module lcd_port_host
	import lcd_port_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// host bus
	lcd_host_if.host         bus,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// wait polarity used by the device
	input  wire logic        wait_active_high
);
	typedef enum {H_IDLE, H_SETUP, H_STROBE, H_HOLD} host_state_t;

	typedef struct packed {
		logic [1:0]  sy_wait;
		logic [15:0] d1, d2;
		host_state_t state;
		logic [3:0]  ctrl;
		logic [17:0] addr;
		logic [15:0] wdata, rdata;
		logic        busy;
		logic        waited;
		logic        cs_n, rd_n, wr_n, hb_n, oe;
		logic        aw_got, w_got;
		logic [7:0]  aw_addr;
		logic [31:0] w_data;
		logic        awready, wready, bvalid, arready, rvalid;
		logic [1:0]  bresp, rresp;
		logic [31:0] rdata_axi;
	} host_st_t;

	host_st_t st_q;
	host_st_t st_d;
	logic wait_on;

	always_comb begin
		st_d = st_q;
		st_d.sy_wait = {st_q.sy_wait[0], bus.wait_out};
		st_d.d1 = bus.host_data_in;
		st_d.d2 = st_q.d1;
		wait_on = st_q.sy_wait[1] == wait_active_high;
		// ************************************************************
		// axi slave
		// ************************************************************
		st_d.awready = 1'b0;
		st_d.wready = 1'b0;
		st_d.arready = 1'b0;
		if (s_axi_awvalid && !st_q.aw_got && !st_q.awready && !st_q.bvalid) st_d.awready = 1'b1;
		if (s_axi_wvalid && !st_q.w_got && !st_q.wready && !st_q.bvalid) st_d.wready = 1'b1;
		if (st_q.awready) begin
			st_d.aw_got = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (st_q.wready) begin
			st_d.w_got = 1'b1;
			st_d.w_data = s_axi_wdata;
		end
		if (st_q.aw_got && st_q.w_got) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = RESP_OKAY;
			unique case (st_q.aw_addr)
				OFF_CTRL: if (!st_q.busy && st_q.w_data[CTRL_GO]) begin
					st_d.ctrl = st_q.w_data[3:0];
					st_d.busy = 1'b1;
					st_d.state = H_SETUP;
				end
				OFF_ADDR:  st_d.addr = st_q.w_data[17:0];
				OFF_WDATA: st_d.wdata = st_q.w_data[15:0];
				default:   st_d.bresp = RESP_SLVERR;
			endcase
		end
		if (st_q.bvalid && s_axi_bready) st_d.bvalid = 1'b0;
		if (s_axi_arvalid && !st_q.arready && !st_q.rvalid) st_d.arready = 1'b1;
		if (st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				OFF_CTRL:   st_d.rdata_axi = {28'h000_0000, st_q.ctrl};
				OFF_ADDR:   st_d.rdata_axi = {14'h0000, st_q.addr};
				OFF_WDATA:  st_d.rdata_axi = {16'h0000, st_q.wdata};
				OFF_RDATA:  st_d.rdata_axi = {16'h0000, st_q.rdata};
				OFF_STATUS: st_d.rdata_axi = {31'h0000_0000, st_q.busy};
				default: begin
					st_d.rdata_axi = 32'h0000_0000;
					st_d.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (st_q.rvalid && s_axi_rready) st_d.rvalid = 1'b0;
		// ************************************************************
		// host bus cycle
		// ************************************************************
		unique case (st_q.state)
			H_IDLE: ;
			H_SETUP: begin
				st_d.cs_n = 1'b0;
				st_d.hb_n = st_q.ctrl[CTRL_BYTE];
				st_d.oe = st_q.ctrl[CTRL_WRITE];
				st_d.waited = 1'b0;
				st_d.state = H_STROBE;
			end
			H_STROBE: begin
				if (st_q.ctrl[CTRL_WRITE]) st_d.wr_n = 1'b0;
				else st_d.rd_n = 1'b0;
				st_d.state = H_HOLD;
			end
			H_HOLD: begin
				if (wait_on) st_d.waited = 1'b1;
				if (st_q.waited && !wait_on && (!st_q.rd_n || !st_q.wr_n)) begin
					if (!st_q.ctrl[CTRL_WRITE]) st_d.rdata = st_q.d2;
					st_d.rd_n = 1'b1;
					st_d.wr_n = 1'b1;
				end else if (st_q.rd_n && st_q.wr_n) begin
					st_d.cs_n = 1'b1;
					st_d.oe = 1'b0;
					st_d.hb_n = 1'b1;
					st_d.busy = 1'b0;
					st_d.state = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '{sy_wait: 2'h3, d1: 16'h0000, d2: 16'h0000, state: H_IDLE, ctrl: 4'h0,
				addr: 18'h0_0000, wdata: 16'h0000, rdata: 16'h0000, busy: 1'b0,
				cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, hb_n: 1'b1, oe: 1'b0, waited: 1'b0,
				aw_got: 1'b0, w_got: 1'b0, aw_addr: 8'h00, w_data: 32'h0000_0000,
				awready: 1'b0, wready: 1'b0, bvalid: 1'b0, arready: 1'b0, rvalid: 1'b0,
				bresp: 2'h0, rresp: 2'h0, rdata_axi: 32'h0000_0000};
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.host_addr_in       = st_q.addr[16:0];
	assign bus.mem_select         = st_q.addr[SEL_BIT];
	assign bus.host_data_out      = st_q.wdata;
	assign bus.host_data_oe       = st_q.oe;
	assign bus.chip_select_n      = st_q.cs_n;
	assign bus.read_strobe_n      = st_q.rd_n;
	assign bus.low_write_strobe_n = st_q.wr_n;
	assign bus.high_byte_enable_n = st_q.hb_n;
	assign bus.bus_start_n        = 1'b1;
	assign bus.rd_wr_dir          = 1'b1;
	assign s_axi_awready          = st_q.awready;
	assign s_axi_wready           = st_q.wready;
	assign s_axi_bresp            = st_q.bresp;
	assign s_axi_bvalid           = st_q.bvalid;
	assign s_axi_arready          = st_q.arready;
	assign s_axi_rdata            = st_q.rdata_axi;
	assign s_axi_rresp            = st_q.rresp;
	assign s_axi_rvalid           = st_q.rvalid;
endmodule : lcd_port_host

// >>> core/lcd_port_pkg.sv
package lcd_port_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	localparam int SEL_BIT = 17;
	localparam int REG_DEPTH = 256;
	localparam int MEM_DEPTH = 40960;
	localparam int MEM_AW = 16;
	localparam int REG_AW = 8;

	// ****************************************************************
	// straps
	// ****************************************************************
	localparam logic [2:0] BUS_GENERIC2 = 3'h4;
	localparam int STRAP_W = 8;
	localparam int STRAP_BUS_LO = 0;
	localparam int STRAP_GPIO = 3;
	localparam int STRAP_ENDIAN = 4;
	localparam int STRAP_WAITPOL = 5;
	localparam int STRAP_DIV_LO = 6;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam logic [3:0] REFRESH_PERIOD = 4'h7;
	localparam logic [1:0] REFRESH_BUSY = 2'h2;
	localparam logic [1:0] ACCESS_CYCLES = 2'h1;

	// ****************************************************************
	// host-end register offsets (axi byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_RDATA = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam int CTRL_GO = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_BYTE = 2;
	localparam int CTRL_MEM = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// byte lane decode from high-byte enable and addr bit 0
	function automatic logic [1:0] lanes(input logic hbe_n, input logic a0);
		return {~hbe_n | a0, ~a0};
	endfunction : lanes

endpackage : lcd_port_pkg

// >>> core/strap_capture.sv
`timescale 1ns/1ps
module strap_capture
	import lcd_port_pkg::*;
(
	// clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// strap pins
	input  wire logic [STRAP_W-1:0] strap_pins,
	// latched configuration
	output logic      [STRAP_W-1:0] strap_q,
	output logic                    ready_q
);
	typedef struct packed {
		logic [STRAP_W-1:0] s1;
		logic [STRAP_W-1:0] s2;
		logic [STRAP_W-1:0] strap;
		logic               in_reset;
		logic               ready;
	} strap_st_t;

	strap_st_t st_q;
	strap_st_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.s1 = strap_pins;
		st_d.s2 = st_q.s1;
		st_d.in_reset = 1'b0;
		// capture once on the first edge after reset release
		if (st_q.in_reset) begin
			st_d.strap = st_q.s2;
			st_d.ready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// keep the sync chain running so the pins are settled at release
			st_q <= '{s1: st_d.s1, s2: st_d.s2, strap: '0, in_reset: 1'b1, ready: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign strap_q = st_q.strap;
	assign ready_q = st_q.ready;
endmodule : strap_capture

// >>> tb/lcd_port_props.sv
`timescale 1ns/1ps
// ****************************************************************
// host bus checks
// ****************************************************************
module lcd_port_props
	import lcd_port_pkg::*;
(
	// clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// host bus
	input  wire logic [16:0]        host_addr_in,
	input  wire logic [15:0]        host_data_out,
	input  wire logic               host_data_oe,
	input  wire logic               dev_data_oe,
	input  wire logic               chip_select_n,
	input  wire logic               read_strobe_n,
	input  wire logic               low_write_strobe_n,
	input  wire logic               high_byte_enable_n,
	input  wire logic               bus_start_n,
	input  wire logic               rd_wr_dir,
	input  wire logic               wait_out,
	// straps
	input  wire logic [STRAP_W-1:0] strap_pins
);
	logic       wact;
	logic       seen_q;
	logic [4:0] idle_q;
	logic [4:0] held_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// wait active level follows the polarity strap
	assign wact = (wait_out == strap_pins[STRAP_WAITPOL]);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen_q <= 1'b0;
			idle_q <= 5'h00;
			held_q <= 5'h00;
		end else begin
			seen_q <= (read_strobe_n & low_write_strobe_n) ? 1'b0 : (seen_q | wact);
			idle_q <= !chip_select_n ? 5'h00 : idle_q + 5'(idle_q != 5'h1f);
			held_q <= !wact ? 5'h00 : held_q + 5'(held_q != 5'h1f);
		end
	end

	a_cs_covers_strobe: assert property (!(read_strobe_n && low_write_strobe_n) |-> !chip_select_n)
		else $error("strobe low without chip select");
	a_one_strobe: assert property (!read_strobe_n |-> low_write_strobe_n)
		else $error("read and write strobes together");
	a_tied_high: assert property (bus_start_n && rd_wr_dir)
		else $error("bus start or direction not high");
	a_no_fight: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive data");
	a_wr_data_held: assert property ((!low_write_strobe_n && $past(!low_write_strobe_n))
		|-> host_data_oe && $stable(host_data_out))
		else $error("write data moved under strobe");
	a_addr_held: assert property ((!chip_select_n && $past(!chip_select_n))
		|-> $stable(host_addr_in) && $stable(high_byte_enable_n))
		else $error("address moved under chip select");
	a_wait_answers: assert property (($fell(read_strobe_n) || $fell(low_write_strobe_n))
		|-> ##[1:40] wact)
		else $error("wait never asserted");
	a_wait_bounded: assert property (held_q < 5'h14)
		else $error("wait held too long");
	a_idle_no_wait: assert property (idle_q >= 5'h06 |-> !wact)
		else $error("wait active while idle");
	a_wait_before_end: assert property (($rose(read_strobe_n) || $rose(low_write_strobe_n))
		|-> seen_q)
		else $error("strobe ended before wait");
	a_data_at_release: assert property (($fell(wact) && !read_strobe_n) |-> dev_data_oe)
		else $error("wait released without read data");
endmodule : lcd_port_props

// >>> tb/tb_lcd_ctrl_generic_host_bus_port.sv
`timescale 1ns/1ps
module tb_lcd_ctrl_generic_host_bus_port
	import lcd_port_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, mode_ok, gpio_in, tick;
	logic [7:0]  strap, awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, cdiv;
	logic [15:0] float_q, x_data;
	logic [17:0] x_addr;
	logic        x_byte, x_wr, armed;
	logic [15:0] mdl [int];
	logic [17:0] pool [8];
	int          errors, n_compared;

	// ****************************************************************
	// ends, wire and checker
	// ****************************************************************
	lcd_host_if bus ();
	assign bus.host_data_in = bus.dev_data_oe ? bus.dev_data_out :
		bus.host_data_oe ? bus.host_data_out : float_q;
	lcd_port_host i_lcd_port_host (.aclk, .aresetn, .bus(bus.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.wait_active_high(strap[STRAP_WAITPOL]));
	lcd_port_device i_lcd_port_device (.aclk, .aresetn, .bus(bus.device), .strap_pins(strap),
		.mode_ok(mode_ok), .gpio_as_input(gpio_in), .clock_divide(cdiv), .bus_clock_tick(tick));
	lcd_port_props i_lcd_port_props (.aclk, .aresetn, .host_addr_in(bus.host_addr_in),
		.host_data_out(bus.host_data_out), .host_data_oe(bus.host_data_oe),
		.dev_data_oe(bus.dev_data_oe), .chip_select_n(bus.chip_select_n),
		.read_strobe_n(bus.read_strobe_n), .low_write_strobe_n(bus.low_write_strobe_n),
		.high_byte_enable_n(bus.high_byte_enable_n), .bus_start_n(bus.bus_start_n),
		.rd_wr_dir(bus.rd_wr_dir), .wait_out(bus.wait_out), .strap_pins(strap));

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) float_q <= ~float_q;

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && t < 100);
		r = bresp;
		bready <= 1'b0;
		if (t >= 100) chk("bvalid", 32'h1, 32'h0);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			t++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && t < 100);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (t >= 100) chk("rvalid", 32'h1, 32'h0);
	endtask : axi_rd

	function automatic int key(input logic [17:0] a);
		return int'({a[17], a[16:1]});
	endfunction : key

	function automatic logic [15:0] sw(input logic [15:0] x, input logic e);
		return e ? {x[7:0], x[15:8]} : x;
	endfunction : sw

	// one host bus access through the control registers, checked against the model
	task automatic op(input logic wr, input logic bm, input logic [17:0] a, input logic [15:0] d);
		logic [1:0]  r;
		logic [1:0]  ln;
		logic [15:0] m;
		logic [31:0] s;
		int          t;
		ln = {~bm | a[0], ~a[0]};
		m = {{8{ln[1]}}, {8{ln[0]}}};
		axi_wr(OFF_ADDR, 32'(a), r);
		axi_wr(OFF_WDATA, 32'(d), r);
		x_addr = a;
		x_byte = bm;
		x_wr = wr;
		x_data = d;
		armed = 1'b1;
		axi_wr(OFF_CTRL, 32'({bm, wr, 1'b1}), r);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
		t = 0;
		do begin
			axi_rd(OFF_STATUS, s, r);
			t++;
		end while (s[0] !== 1'b0 && t < 50);
		chk("busy", 32'h0, 32'(s[0]));
		chk("access", 32'h0, 32'(armed));
		axi_rd(OFF_RDATA, s, r);
		if (wr) mdl[key(a)] = ((mdl.exists(key(a)) ? mdl[key(a)] : 16'h0000) & ~m)
			| (sw(d, strap[STRAP_ENDIAN]) & m);
		else if (mdl.exists(key(a)))
			chk("rdata", 32'(sw(mdl[key(a)], strap[STRAP_ENDIAN]) & m), 32'(s[15:0] & m));
	endtask : op

	// bus-side view of each access
	always @(posedge aclk) begin
		if (armed && bus.chip_select_n === 1'b0
			&& (bus.read_strobe_n === 1'b0 || bus.low_write_strobe_n === 1'b0)) begin
			armed <= 1'b0;
			chk("addr", 32'(x_addr[16:0]), 32'(bus.host_addr_in));
			chk("msel", 32'(x_addr[17]), 32'(bus.mem_select));
			chk("hbe", 32'(x_byte), 32'(bus.high_byte_enable_n));
			chk("dir", 32'(x_wr), 32'(!bus.low_write_strobe_n));
			if (x_wr) chk("wdata", 32'(x_data), 32'(bus.host_data_out));
		end
	end

	task automatic do_reset(input logic [7:0] s);
		int n;
		@(posedge aclk);
		aresetn <= 1'b0;
		strap <= s;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("mode", 32'(s[2:0] == BUS_GENERIC2), 32'(mode_ok));
		chk("gpio", 32'(s[STRAP_GPIO]), 32'(gpio_in));
		chk("div", 32'(s[7:6]), 32'(cdiv));
		n = 0;
		while (tick !== 1'b1 && n < 20) begin
			@(posedge aclk);
			n++;
		end
		@(posedge aclk);
		n = 1;
		while (tick !== 1'b1 && n < 20) begin
			@(posedge aclk);
			n++;
		end
		chk("tick", 32'(s[7:6]) + 32'h1, 32'(n));
	endtask : do_reset

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		logic [7:0]  cfgs [4];
		logic [31:0] s;
		logic [1:0]  r;
		logic        bm;
		int          w;
		cfgs = '{8'h0c, 8'h74, 8'hac, 8'hc1};
		{aresetn, awvalid, wvalid, bready, arvalid, rready, armed} = 7'h00;
		{awaddr, araddr, wdata, strap} = 56'h0;
		float_q = 16'h5a5a;
		errors = 0;
		n_compared = 0;
		w = $urandom(7);
		for (int i = 0; i < 8; i++) begin
			w = $urandom % (i < 4 ? 256 : 40960);
			pool[i] = {i >= 4, w[15:0], 1'b0};
		end
		for (int k = 0; k < 4; k++) begin
			do_reset(cfgs[k]);
			for (int i = 0; i < 4; i++) mdl.delete(key(pool[i]));
			if (cfgs[k][2:0] == BUS_GENERIC2) begin
				for (int i = 4; i < 8; i++) op(1'b0, 1'b0, pool[i], 16'h0000);
				for (int i = 0; i < 8; i++) op(1'b1, 1'b0, pool[i], 16'($urandom));
				for (int i = 0; i < 24; i++) begin
					bm = strap[STRAP_ENDIAN] ? 1'b0 : 1'($urandom);
					w = $urandom % 8;
					op(1'($urandom), bm, {pool[w][17:1], bm & 1'($urandom)}, 16'($urandom));
				end
			end
			axi_rd(8'h14, s, r);
			chk("rresp", 32'(RESP_SLVERR), 32'(r));
			chk("unmapped", 32'h0, s);
			axi_wr(8'h14, 32'h0, r);
			chk("bresp", 32'(RESP_SLVERR), 32'(r));
		end
		test_done;
	end

	initial begin
		#400000;
		chk("watchdog", 32'h0, 32'h1);
		test_done;
	end
endmodule : tb_lcd_ctrl_generic_host_bus_port
